/* File: logic/buffer_address_pointers.v */
// Operation
// - Read pointer addresses RAM for host read or disk write.
// - Write pointer addresses RAM for host write or disk read.
// - Each memory cycle: low byte with strobe, then high byte with enable.
// - Read, write, stop pointers are 16 bits as low and high bytes.
// - Active pointer increments by one per byte moved.
// - On increment, compare stop with the old read or write pointer by direction.
// - A match halts the DMA operation.
// - Buffer size masks upper bits out of the stop comparison.
// - Bytes moved equal stop minus current plus one while the host owns the buffer.
// - Latch command during DMA freezes pointer values seen by reads.
// - Any read of a read or write pointer byte releases the latch.
// - Writing the reset location clears all three pointers.
`timescale 1ns/1ps
`default_nettype none
`include "buffer_pointer_defs.vh"
module buffer_address_pointers (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        byte_moved,
   output wire [7:0]  buffer_addr,
   output wire        memory_addr_latch_strobe,
   output wire        memory_output_enable_n,
   output reg         dma_active_ff
);
   reg  [15:0] read_pointer_ff;
   reg  [15:0] write_pointer_ff;
   reg  [15:0] stop_pointer_ff;
   reg  [15:0] read_latch_ff;
   reg  [15:0] write_latch_ff;
   reg         latched_ff;
   reg  [7:0]  buffer_size_ff;
   reg         dir_write_ff;
   reg         disk_owns_ff;
   reg         done_flag_ff;
   reg  [11:0] awaddr_ff;
   reg  [31:0] wdata_ff;
   reg  [3:0]  wstrb_ff;
   reg         aw_held_ff;
   reg         w_held_ff;
   reg         cycle_pending_ff;

   wire [15:0] size_mask = {buffer_size_ff, 8'hff};
   wire        use_read_ptr = dir_write_ff ? disk_owns_ff : !disk_owns_ff;
   wire [15:0] current_pointer = use_read_ptr ? read_pointer_ff : write_pointer_ff;
   wire        seq_busy;
   wire        seq_done;

   // New memory cycle only when idle and no pointer update is still owed
   wire        seq_start = dma_active_ff && byte_moved && !seq_busy && !cycle_pending_ff;

   // Stop compare takes the pointer chosen by transfer direction
   function stop_match;
      input [15:0] ptr;
      input [15:0] stop;
      input [15:0] mask;
      begin
         stop_match = ((ptr ^ stop) & mask) == 16'h0000;
      end
   endfunction

   // Incremented pointer, upper bits frozen outside the buffer size
   function [15:0] next_pointer;
      input [15:0] ptr;
      input [15:0] mask;
      reg   [15:0] sum;
      begin
         sum          = ptr + 16'h0001;
         next_pointer = (sum & mask) | (ptr & ~mask);
      end
   endfunction

   // Word aligned and inside the register window
   function addr_ok;
      input [11:0] addr;
      begin
         addr_ok = (addr[1:0] == 2'b00) && (addr[11:10] == 2'b00);
      end
   endfunction

   address_phase_sequencer u_seq (
      .aclk               (aclk),
      .aresetn            (aresetn),
      .start              (seq_start),
      .address            (current_pointer),
      .busy_ff            (seq_busy),
      .done_ff            (seq_done),
      .ram_addr_ff        (buffer_addr),
      .addr_strobe_ff     (memory_addr_latch_strobe),
      .output_enable_n_ff (memory_output_enable_n)
   );

   wire        wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid;
   wire [7:0]  wr_idx  = awaddr_ff[9:2];
   wire        wr_ok   = addr_ok(awaddr_ff);
   wire        wr_en   = wr_fire && wr_ok && wstrb_ff[0];
   wire [7:0]  wbyte   = wdata_ff[7:0];

   wire [7:0]  rd_idx  = s_axi_araddr[9:2];
   wire        rd_fire = s_axi_arvalid && s_axi_arready;
   wire        rd_ok   = addr_ok(s_axi_araddr);
   // Readback views: frozen copies while the latch is closed
   wire [15:0] rp_view = latched_ff ? read_latch_ff : read_pointer_ff;
   wire [15:0] wp_view = latched_ff ? write_latch_ff : write_pointer_ff;
   reg  [7:0]  rd_byte;
   reg         rd_hit;
   reg         rd_ptr;

   // Old pointer equal to stop means this byte was the last
   wire        halt_now = seq_done && cycle_pending_ff &&
                          stop_match(dir_write_ff ? write_pointer_ff : read_pointer_ff,
                                     stop_pointer_ff, size_mask);

   // Register read mux; unmapped words answer with an error
   always @* begin
      rd_byte = 8'h00;
      rd_hit  = 1'b1;
      rd_ptr  = 1'b0;
      case (rd_idx)
         `IDX_READ_PTR_LOW: begin
            rd_byte = rp_view[7:0];
            rd_ptr  = 1'b1;
         end
         `IDX_READ_PTR_HIGH: begin
            rd_byte = rp_view[15:8];
            rd_ptr  = 1'b1;
         end
         `IDX_WRITE_PTR_LOW: begin
            rd_byte = wp_view[7:0];
            rd_ptr  = 1'b1;
         end
         `IDX_WRITE_PTR_HIGH: begin
            rd_byte = wp_view[15:8];
            rd_ptr  = 1'b1;
         end
         `IDX_STOP_PTR_LOW:   rd_byte = stop_pointer_ff[7:0];
         `IDX_STOP_PTR_HIGH:  rd_byte = stop_pointer_ff[15:8];
         `IDX_BUFFER_SIZE:    rd_byte = buffer_size_ff;
         `IDX_DMA_CONTROL: begin
            rd_byte = 8'h00;
            rd_byte[`CTL_DIR_BIT]       = dir_write_ff;
            rd_byte[`CTL_DISK_OWNS_BIT] = disk_owns_ff;
         end
         `IDX_DMA_STATUS: begin
            rd_byte = 8'h00;
            rd_byte[`STS_BUSY_BIT]    = dma_active_ff;
            rd_byte[`STS_DONE_BIT]    = done_flag_ff;
            rd_byte[`STS_LATCHED_BIT] = latched_ff;
         end
         `IDX_LATCH_POINTERS: rd_byte = 8'h00;
         `IDX_RESET_POINTERS: rd_byte = 8'h00;
         default:             rd_hit  = 1'b0;
      endcase
      if (!rd_ok) begin
         rd_hit = 1'b0;
      end
   end

   // Write channel capture, address and data in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff    <= 1'b0;
         w_held_ff     <= 1'b0;
         awaddr_ff     <= 12'h000;
         wdata_ff      <= 32'h00000000;
         wstrb_ff      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `AXI_RESP_OKAY;
      end else begin
         // Ready pulses one cycle, so each channel takes exactly one beat
         s_axi_awready <= !aw_held_ff && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_held_ff && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata;
            wstrb_ff  <= s_axi_wstrb;
         end
         // Response only once the previous one has been taken
         if (wr_fire) begin
            aw_held_ff   <= 1'b0;
            w_held_ff    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `AXI_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         // Data captured as the address is taken
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_byte};
            s_axi_rresp  <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Pointers, latch and DMA control
   always @(posedge aclk) begin
      if (!aresetn) begin
         read_pointer_ff  <= 16'h0000;
         write_pointer_ff <= 16'h0000;
         stop_pointer_ff  <= 16'h0000;
         read_latch_ff    <= 16'h0000;
         write_latch_ff   <= 16'h0000;
         latched_ff       <= 1'b0;
         buffer_size_ff   <= `BUFFER_SIZE_RESET;
         dir_write_ff     <= 1'b0;
         disk_owns_ff     <= 1'b0;
         dma_active_ff    <= 1'b0;
         done_flag_ff     <= 1'b0;
         cycle_pending_ff <= 1'b0;
      end else begin
         // Pointer update is owed from start until the done pulse after the high phase
         if (seq_start) begin
            cycle_pending_ff <= 1'b1;
         end

         if (seq_done && cycle_pending_ff) begin
            cycle_pending_ff <= 1'b0;
            if (use_read_ptr) begin
               read_pointer_ff <= next_pointer(read_pointer_ff, size_mask);
            end else begin
               write_pointer_ff <= next_pointer(write_pointer_ff, size_mask);
            end
            if (halt_now) begin
               dma_active_ff <= 1'b0;
               done_flag_ff  <= 1'b1;
            end
         end

         // Any read or write pointer byte read reopens the latch
         if (rd_fire && rd_hit && rd_ptr) begin
            latched_ff <= 1'b0;
         end

         // Register writes override the transfer updates above
         if (wr_en) begin
            case (wr_idx)
               `IDX_READ_PTR_LOW:   read_pointer_ff[7:0]   <= wbyte;
               `IDX_READ_PTR_HIGH:  read_pointer_ff[15:8]  <= wbyte;
               `IDX_WRITE_PTR_LOW:  write_pointer_ff[7:0]  <= wbyte;
               `IDX_WRITE_PTR_HIGH: write_pointer_ff[15:8] <= wbyte;
               `IDX_STOP_PTR_LOW:   stop_pointer_ff[7:0]   <= wbyte;
               `IDX_STOP_PTR_HIGH:  stop_pointer_ff[15:8]  <= wbyte;
               `IDX_BUFFER_SIZE:    buffer_size_ff         <= wbyte;
               `IDX_RESET_POINTERS: begin
                  read_pointer_ff  <= 16'h0000;
                  write_pointer_ff <= 16'h0000;
                  stop_pointer_ff  <= 16'h0000;
               end
               `IDX_LATCH_POINTERS: begin
                  // Outside a transfer the live pointers are already still
                  if (dma_active_ff) begin
                     read_latch_ff  <= read_pointer_ff;
                     write_latch_ff <= write_pointer_ff;
                     latched_ff     <= 1'b1;
                  end
               end
               `IDX_DMA_CONTROL: begin
                  dir_write_ff <= wbyte[`CTL_DIR_BIT];
                  disk_owns_ff <= wbyte[`CTL_DISK_OWNS_BIT];
                  if (wbyte[`CTL_START_BIT]) begin
                     dma_active_ff <= 1'b1;
                     done_flag_ff  <= 1'b0;
                  end else begin
                     dma_active_ff <= 1'b0;
                  end
               end
               `IDX_DMA_STATUS: begin
                  // A halt in the same cycle keeps the done flag set
                  if (!halt_now) begin
                     done_flag_ff <= 1'b0;
                  end
               end
               default: ;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* File: logic/buffer_pointer_defs.vh */
`ifndef BUFFER_POINTER_DEFS_VH
`define BUFFER_POINTER_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_LATCH_POINTERS  8'h55
`define IDX_BUFFER_SIZE     8'h54
`define IDX_RESET_POINTERS  8'h59
`define IDX_READ_PTR_LOW    8'h5a
`define IDX_READ_PTR_HIGH   8'h5b
`define IDX_WRITE_PTR_LOW   8'h5c
`define IDX_WRITE_PTR_HIGH  8'h5d
`define IDX_STOP_PTR_LOW    8'h5e
`define IDX_STOP_PTR_HIGH   8'h5f
`define IDX_DMA_CONTROL     8'h70
`define IDX_DMA_STATUS      8'h71

// Control register fields
`define CTL_START_BIT       0
`define CTL_DIR_BIT         1
`define CTL_DISK_OWNS_BIT   2

// Status register fields
`define STS_BUSY_BIT        0
`define STS_DONE_BIT        1
`define STS_LATCHED_BIT     2

`define BUFFER_SIZE_RESET   8'hff
`define AXI_RESP_OKAY       2'b00
`define AXI_RESP_SLVERR     2'b10

`endif

/* File: logic/address_phase_sequencer.v */
`timescale 1ns/1ps
`default_nettype none
// One memory cycle: low byte with latch strobe, then high byte with output enable
module address_phase_sequencer (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        start,
   input  wire [15:0] address,
   output reg         busy_ff,
   output reg         done_ff,
   output reg  [7:0]  ram_addr_ff,
   output reg         addr_strobe_ff,
   output reg         output_enable_n_ff
);
   localparam IDLE = 2'd0;
   localparam LOW  = 2'd1;
   localparam HIGH = 2'd2;

   reg [1:0] state_ff;
   reg [7:0] high_ff;

   always @(posedge aclk) begin
      if (!aresetn) begin
         state_ff           <= IDLE;
         high_ff            <= 8'h00;
         busy_ff            <= 1'b0;
         done_ff            <= 1'b0;
         ram_addr_ff        <= 8'h00;
         addr_strobe_ff     <= 1'b0;
         output_enable_n_ff <= 1'b1;
      end else begin
         done_ff <= 1'b0;
         case (state_ff)
            IDLE: begin
               output_enable_n_ff <= 1'b1;
               if (start) begin
                  ram_addr_ff    <= address[7:0];
                  high_ff        <= address[15:8];
                  addr_strobe_ff <= 1'b1;
                  busy_ff        <= 1'b1;
                  state_ff       <= LOW;
               end
            end
            LOW: begin
               ram_addr_ff        <= high_ff;
               addr_strobe_ff     <= 1'b0;
               output_enable_n_ff <= 1'b0;
               state_ff           <= HIGH;
            end
            HIGH: begin
               output_enable_n_ff <= 1'b1;
               busy_ff            <= 1'b0;
               done_ff            <= 1'b1;
               state_ff           <= IDLE;
            end
            default: state_ff <= IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: test/buffer_address_pointers_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module buffer_address_pointers_sva (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        byte_moved,
   input wire logic        memory_addr_latch_strobe,
   input wire logic        memory_output_enable_n,
   input wire logic        dma_active_ff,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready
);
   wire stb = memory_addr_latch_strobe;
   wire oen = memory_output_enable_n;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_low_then_high: assert property (stb |=> !oen && !stb)
      else $error("high address phase missing");
   chk_high_after_low: assert property ($fell(oen) |-> $past(stb))
      else $error("enable without preceding strobe");
   chk_enable_single: assert property (!oen |=> oen)
      else $error("enable longer than one cycle");
   chk_byte_cause: assert property ($rose(stb) |-> $past(byte_moved))
      else $error("memory cycle without byte request");
   chk_halt_quiet: assert property (stb |-> dma_active_ff)
      else $error("memory cycle while halted");
   chk_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
endmodule
bind buffer_address_pointers buffer_address_pointers_sva u_sva (.*);
`default_nettype wire

/* File: test/buffer_ram_model.sv */
`timescale 1ns/1ps
`default_nettype none
module buffer_ram_model (
   input wire logic        aclk,
   input wire logic        addr_strobe,
   input wire logic        output_enable_n,
   input wire logic [7:0]  buffer_addr,
   output logic     [15:0] last_addr
);
   logic [7:0] low_ff = 8'h0;
   always @(posedge aclk) begin
      if (addr_strobe)
         low_ff <= buffer_addr;
      if (!output_enable_n)
         last_addr <= {buffer_addr, low_ff};
   end
endmodule
`default_nettype wire

/* File: test/buffer_address_pointers_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "buffer_pointer_defs.vh"
module buffer_address_pointers_bench;
   logic        aclk = 1'b0, aresetn = 1'b0, byte_moved = 1'b0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire         awready, wready, bvalid, arready, rvalid, strobe, oe_n, active;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [7:0]  baddr;
   wire  [15:0] ram_addr;
   int          fails = 0, comparisons = 0;
   buffer_address_pointers uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .byte_moved(byte_moved), .buffer_addr(baddr), .memory_addr_latch_strobe(strobe),
      .memory_output_enable_n(oe_n), .dma_active_ff(active));
   buffer_ram_model ram (.aclk(aclk), .addr_strobe(strobe), .output_enable_n(oe_n),
      .buffer_addr(baddr), .last_addr(ram_addr));
   always #5 aclk = ~aclk;
   task automatic test_done;
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic hang;
      fails++;
      test_done;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic reset_dut;
      aresetn <= 1'b0;
      tick(20);
      aresetn <= 1'b1;
      tick(1);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
      int k;
      awaddr <= {2'b00, idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 40 && !bvalid; k++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      if (k >= 40) hang;
      chk(16'(bresp), 16'(er));
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [15:0] exp, input logic [1:0] er);
      int k;
      araddr <= {2'b00, idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 40 && !rvalid; k++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      if (k >= 40) hang;
      chk(rdata[15:0], exp);
      chk(16'(rresp), 16'(er));
      @(posedge aclk);
   endtask
   task automatic rd_slow(input logic [7:0] idx, input logic [15:0] exp);
      int k;
      araddr <= {2'b00, idx, 2'b00};
      arvalid <= 1'b1;
      for (k = 0; k < 40 && !rvalid; k++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end
      if (k >= 40) hang;
      tick(2);
      rready <= 1'b1;
      @(posedge aclk);
      rready <= 1'b0;
      chk(rdata[15:0], exp);
      chk(16'(rresp), 16'h0);
      @(posedge aclk);
   endtask
   task automatic set16(input logic [7:0] idx, input logic [15:0] v);
      wr(idx, v[7:0], 2'b00);
      wr(idx + 8'h1, v[15:8], 2'b00);
   endtask
   task automatic mv(input logic [15:0] exp);
      int k;
      chk(16'(active), 16'h1);
      byte_moved <= 1'b1;
      for (k = 0; k < 40 && !strobe; k++)
         @(posedge aclk);
      byte_moved <= 1'b0;
      tick(4);
      if (k >= 40) hang;
      chk(ram_addr, exp);
   endtask
   task automatic t_regs;
      int i;
      for (i = 0; i < 6; i++)
         rd(`IDX_READ_PTR_LOW + 8'(i), 16'h0, 2'b00);
      for (i = 0; i < 6; i++)
         wr(`IDX_READ_PTR_LOW + 8'(i), 8'hc0 + 8'(i), 2'b00);
      for (i = 0; i < 6; i++)
         rd(`IDX_READ_PTR_LOW + 8'(i), 16'h00c0 + 16'(i), 2'b00);
      rd_slow(`IDX_STOP_PTR_HIGH, 16'h00c5);
      wr(`IDX_RESET_POINTERS, 8'h7e, 2'b00);
      for (i = 0; i < 6; i++)
         rd(`IDX_READ_PTR_LOW + 8'(i), 16'h0, 2'b00);
      wr(8'h00, 8'h12, `AXI_RESP_OKAY);
      rd(8'h00, 16'h0, `AXI_RESP_SLVERR);
   endtask
   task automatic t_dma(input logic [7:0] ctl, input logic [15:0] r, input logic [15:0] w,
                        input logic [15:0] s, input logic [7:0] size, input int n);
      logic [15:0] p, q;
      logic [7:0]  idx;
      int          i;
      p = (ctl[1] == ctl[2]) ? r : w;
      q = p + 16'(n);
      idx = ctl[1] ? `IDX_WRITE_PTR_LOW : `IDX_READ_PTR_LOW;
      wr(`IDX_BUFFER_SIZE, size, 2'b00);
      set16(`IDX_READ_PTR_LOW, r);
      set16(`IDX_WRITE_PTR_LOW, w);
      set16(`IDX_STOP_PTR_LOW, s);
      wr(`IDX_DMA_CONTROL, ctl, 2'b00);
      for (i = 0; i < n; i++)
         mv(p + 16'(i));
      if (ctl[2])
         reset_dut;
      else begin
         chk(16'(active), 16'h0);
         rd(idx, {8'h0, q[7:0]}, 2'b00);
         rd(idx + 8'h1, {8'h0, q[15:8]}, 2'b00);
         rd(`IDX_DMA_STATUS, 16'h0002, 2'b00);
         wr(`IDX_DMA_STATUS, 8'h00, 2'b00);
         rd(`IDX_DMA_STATUS, 16'h0000, 2'b00);
         rd(`IDX_BUFFER_SIZE, {8'h0, size}, 2'b00);
         rd(`IDX_DMA_CONTROL, {8'h0, ctl & 8'h06}, 2'b00);
      end
   endtask
   task automatic t_latch;
      set16(`IDX_WRITE_PTR_LOW, 16'h0100);
      set16(`IDX_STOP_PTR_LOW, 16'h01ff);
      wr(`IDX_DMA_CONTROL, 8'h03, 2'b00);
      mv(16'h0100);
      wr(`IDX_LATCH_POINTERS, 8'h00, 2'b00);
      rd(`IDX_DMA_STATUS, 16'h0005, 2'b00);
      mv(16'h0101);
      rd(`IDX_WRITE_PTR_LOW, 16'h0001, 2'b00);
      rd(`IDX_WRITE_PTR_LOW, 16'h0002, 2'b00);
      reset_dut;
   endtask
   initial begin
      reset_dut;
      t_regs;
      t_dma(8'h01, 16'h1230, 16'h4560, 16'h1233, 8'hff, 4);
      t_dma(8'h03, 16'h1230, 16'h4560, 16'h4562, 8'hff, 3);
      t_dma(8'h05, 16'h1230, 16'h4560, 16'h4560, 8'hff, 1);
      t_dma(8'h07, 16'h1230, 16'h4560, 16'h1230, 8'hff, 1);
      t_dma(8'h01, 16'hffff, 16'h0000, 16'h0000, 8'hff, 2);
      t_dma(8'h01, 16'h0005, 16'h0000, 16'hf005, 8'h0f, 1);
      t_dma(8'h03, 16'h0000, 16'h0040, 16'h0040, 8'hff, 1);
      t_latch;
      test_done;
   end
   initial begin
      tick(20000);
      hang;
   end
endmodule
`default_nettype wire
